// file: core/lcd_drive_pkg.sv
// Shared constants for the multiplexed LCD drive block.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
package lcd_drive_pkg;

    // Clock and the divided system timebase
    localparam int CLK_HZ = 25_000_000;
    localparam int FSYS_HZ = 32768;
    localparam int TICK_CYC = CLK_HZ / FSYS_HZ;
    localparam int DIV_W = 10;

    // Panel geometry
    localparam int NUM_COM = 4;
    localparam int NUM_SEG = 44;
    localparam int RAM_BYTES = 22;
    localparam logic [4:0] RAM_LAST = 5'h15;

    // Frame rates, slot lengths in system ticks
    localparam int FRAME_HZ_LO = 80;
    localparam int FRAME_HZ_HI = 160;
    localparam int SLOT_LO = FSYS_HZ / (FRAME_HZ_LO * NUM_COM);
    localparam int SLOT_HI = FSYS_HZ / (FRAME_HZ_HI * NUM_COM);
    localparam int SLOT_W = 7;

    // Blink divisors; mode m uses counter bit BLINK_BASE + m
    localparam int BLINK_DIV1 = 16384;
    localparam int BLINK_DIV2 = 32768;
    localparam int BLINK_DIV3 = 65536;
    localparam int BLINK_W = $clog2(BLINK_DIV3);
    localparam int BLINK_BASE = $clog2(BLINK_DIV1) - 2;
    localparam logic [1:0] BLINK_OFF = 2'h0;

    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PTR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;

    // Control register fields
    localparam int CB_OSC = 0;
    localparam int CB_BIAS = 1;
    localparam int CB_DISP = 2;
    localparam int CB_HALF = 3;
    localparam int CB_F160 = 4;
    localparam int CB_BLINK = 5;
    localparam int CB_VADJ = 7;
    localparam int CB_DET = 8;
    localparam int CB_VSTEP = 9;
    localparam int CTRL_W = 13;
    localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0080;

    // Drive level codes handed to the analog drivers
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_LO = 2'h1;
    localparam logic [1:0] LVL_HI = 2'h2;
    localparam logic [1:0] LVL_VDD = 2'h3;

    // Bus handshake states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_st_t;

endpackage : lcd_drive_pkg

// file: core/lcd_ram_if.sv
// Link between the drive control and the display memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface lcd_ram_if;
    import lcd_drive_pkg::*;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] rd_addr;
    logic [7:0] rd_data;
    logic [1:0] com_sel;
    logic [NUM_SEG-1:0] col_bits;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, com_sel, input rd_data, col_bits);
    modport store (input wr_en, wr_addr, wr_data, rd_addr, com_sel, output rd_data, col_bits);
endinterface : lcd_ram_if

// file: core/lcd_disp_ram.sv
// Display memory: 22 bytes, two segments of four commons per byte.
// Assumes writes come from the drive control on the same clock.
`timescale 1ns/1ps
module lcd_disp_ram
    import lcd_drive_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    lcd_ram_if.store ram
);

    typedef struct packed {
        logic [RAM_BYTES-1:0][7:0] mem;
    } ram_st_t;

    ram_st_t st_r;
    ram_st_t st_nxt;

    // Byte write at the given index
    always_comb
    begin
        st_nxt = st_r;
        if (ram.wr_en && ram.wr_addr <= RAM_LAST)
        begin
            st_nxt.mem[ram.wr_addr] = ram.wr_data;
        end
    end

    // Storage; cleared on reset so the panel never shows junk
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Read port for software
    assign ram.rd_data = (ram.rd_addr <= RAM_LAST) ? st_r.mem[ram.rd_addr] : 8'h00;

    // Column for the selected common: even segment in low nibble, odd in high
    for (genvar g = 0; g < NUM_SEG; g++)
    begin : g_col
        assign ram.col_bits[g] = st_r.mem[g/2][(g%2)*4 + int'(ram.com_sel)];
    end

    a_ram_write : assert property (@(posedge mclk) disable iff (rst)
        (ram.wr_en && ram.wr_addr <= RAM_LAST) |=> st_r.mem[$past(ram.wr_addr)]
        == $past(ram.wr_data)) else $error("display memory byte not stored");

endmodule : lcd_disp_ram

// file: core/lcd_mux_drive.sv
// Multiplexed LCD drive control: registers, timebase, common scan, blink.
// Assumes an Avalon-MM master on mclk and analog drivers that decode level codes.
`timescale 1ns/1ps

module lcd_mux_drive
    import lcd_drive_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [2*NUM_COM-1:0] common_outputs,
    output logic [2*NUM_SEG-1:0] segment_outputs,
    output logic osc_running,
    output logic bias_gen_en,
    output logic bypass_mid_res,
    output logic vadj_en,
    output logic lcd_supply_detect_en,
    output logic [3:0] voltage_step_field
);

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [4:0] ptr;
        logic [DIV_W-1:0] div;
        logic tick;
        logic [SLOT_W-1:0] slot_cnt;
        logic [1:0] com_idx;
        logic pol;
        logic [BLINK_W-1:0] blink_cnt;
        bus_st_t bus;
        logic waitreq;
        logic [31:0] readdata;
        logic [2*NUM_COM-1:0] com_out;
        logic [2*NUM_SEG-1:0] seg_out;
    } drv_st_t;

    drv_st_t st_r;
    drv_st_t st_nxt;
    logic run;
    logic blank;
    logic data_wr;
    logic [SLOT_W-1:0] slot_last;
    logic [31:0] rd_value;

    lcd_ram_if ram ();

    // Level code for one output from its select/on state and frame polarity
    function automatic logic [1:0] drive_lvl(input logic active, input logic is_com,
                                             input logic pol);
        logic up;
        up = is_com ^ pol;
        if (active)
        begin
            drive_lvl = up ? LVL_VDD : LVL_VSS;
        end
        else
        begin
            drive_lvl = up ? LVL_LO : LVL_HI;
        end
    endfunction : drive_lvl

    // Register decode used by read mux and write path
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] offs);
        hit = (addr == offs);
    endfunction : hit

    // Display memory
    lcd_disp_ram u_ram (
        .mclk(mclk),
        .rst(rst),
        .ram(ram)
    );

    // Memory hookup: write at pointer, column of the current common
    assign data_wr = (st_r.bus == BUS_ACK) && avs_write && hit(avs_address, REG_DATA)
                     && avs_byteenable[0];
    assign ram.wr_en = data_wr;
    assign ram.wr_addr = st_r.ptr;
    assign ram.wr_data = avs_writedata[7:0];
    assign ram.rd_addr = st_r.ptr;
    assign ram.com_sel = st_r.com_idx;

    // Scan runs only with oscillator started and display on
    assign run = st_r.ctrl[CB_OSC] && st_r.ctrl[CB_DISP];
    assign slot_last = st_r.ctrl[CB_F160] ? SLOT_W'(SLOT_HI - 1) : SLOT_W'(SLOT_LO - 1);
    assign blank = (st_r.ctrl[CB_BLINK +: 2] != BLINK_OFF)
                   && st_r.blink_cnt[BLINK_BASE + int'(st_r.ctrl[CB_BLINK +: 2])];

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (hit(avs_address, REG_CTRL))
        begin
            rd_value[CTRL_W-1:0] = st_r.ctrl;
        end
        else if (hit(avs_address, REG_PTR))
        begin
            rd_value[4:0] = st_r.ptr;
        end
        else if (hit(avs_address, REG_DATA))
        begin
            rd_value[7:0] = ram.rd_data;
        end
        else if (hit(avs_address, REG_STAT))
        begin
            rd_value[5:0] = {blank, st_r.pol, st_r.com_idx, st_r.ctrl[CB_OSC], run};
        end
    end

    // Next state of the whole block
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;

        // System timebase, stopped until software starts it
        if (st_r.ctrl[CB_OSC])
        begin
            if (st_r.div == DIV_W'(TICK_CYC - 1))
            begin
                st_nxt.div = '0;
                st_nxt.tick = 1'b1;
            end
            else
            begin
                st_nxt.div = st_r.div + DIV_W'(1);
            end
        end
        else
        begin
            st_nxt.div = '0;
        end

        // Blink divider counts system ticks
        if (!st_r.ctrl[CB_OSC])
        begin
            st_nxt.blink_cnt = '0;
        end
        else if (st_r.tick)
        begin
            st_nxt.blink_cnt = st_r.blink_cnt + BLINK_W'(1);
        end

        // Common slot scan, polarity flips each frame
        if (!run)
        begin
            st_nxt.slot_cnt = '0;
            st_nxt.com_idx = 2'h0;
            st_nxt.pol = 1'b0;
        end
        else if (st_r.tick)
        begin
            if (st_r.slot_cnt >= slot_last)
            begin
                st_nxt.slot_cnt = '0;
                st_nxt.com_idx = st_r.com_idx + 2'h1;
                if (st_r.com_idx == 2'(NUM_COM - 1))
                begin
                    st_nxt.pol = ~st_r.pol;
                end
            end
            else
            begin
                st_nxt.slot_cnt = st_r.slot_cnt + SLOT_W'(1);
            end
        end

        // Drive codes; idle at supply level while not scanning
        for (int i = 0; i < NUM_COM; i++)
        begin
            st_nxt.com_out[2*i +: 2] = run ?
                drive_lvl(st_r.com_idx == 2'(i), 1'b1, st_r.pol) : LVL_VDD;
        end
        for (int i = 0; i < NUM_SEG; i++)
        begin
            st_nxt.seg_out[2*i +: 2] = run ?
                drive_lvl(ram.col_bits[i] && !blank, 1'b0, st_r.pol) : LVL_VDD;
        end

        // Bus slave: one wait cycle, then one cycle with waitrequest low
        case (st_r.bus)
            BUS_IDLE:
            begin
                if (avs_read || avs_write)
                begin
                    st_nxt.bus = BUS_ACK;
                    st_nxt.waitreq = 1'b0;
                    st_nxt.readdata = avs_read ? rd_value : 32'h0000_0000;
                end
            end
            BUS_ACK:
            begin
                st_nxt.bus = BUS_IDLE;
                st_nxt.waitreq = 1'b1;
                if (avs_write && hit(avs_address, REG_CTRL))
                begin
                    if (avs_byteenable[0])
                    begin
                        st_nxt.ctrl[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1])
                    begin
                        st_nxt.ctrl[CTRL_W-1:8] = avs_writedata[CTRL_W-1:8];
                    end
                end
                else if (avs_write && hit(avs_address, REG_PTR) && avs_byteenable[0])
                begin
                    st_nxt.ptr = (avs_writedata[4:0] > RAM_LAST) ? 5'h00 : avs_writedata[4:0];
                end
                else if (data_wr)
                begin
                    st_nxt.ptr = (st_r.ptr == RAM_LAST) ? 5'h00 : st_r.ptr + 5'h01;
                end
            end
            default:
            begin
                st_nxt.bus = BUS_IDLE;
                st_nxt.waitreq = 1'b1;
            end
        endcase
    end

    // State register with power-on defaults
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RST;
            st_r.bus <= BUS_IDLE;
            st_r.waitreq <= 1'b1;
            st_r.com_out <= {NUM_COM{LVL_VDD}};
            st_r.seg_out <= {NUM_SEG{LVL_VDD}};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from state
    assign avs_readdata = st_r.readdata;
    assign avs_waitrequest = st_r.waitreq;
    assign common_outputs = st_r.com_out;
    assign segment_outputs = st_r.seg_out;
    assign osc_running = st_r.ctrl[CB_OSC];
    assign bias_gen_en = st_r.ctrl[CB_BIAS];
    assign bypass_mid_res = st_r.ctrl[CB_HALF];
    assign vadj_en = st_r.ctrl[CB_VADJ];
    assign lcd_supply_detect_en = st_r.ctrl[CB_DET];
    assign voltage_step_field = st_r.ctrl[CB_VSTEP +: 4];

    a_reset_com_idle : assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> common_outputs == {NUM_COM{LVL_VDD}})
        else $error("commons not idle after reset");

    a_reset_seg_idle : assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> segment_outputs == {NUM_SEG{LVL_VDD}})
        else $error("segments not idle after reset");

    a_reset_mode_bits : assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> !bypass_mid_res && !st_r.ctrl[CB_F160] && !st_r.ctrl[CB_DISP]
        && st_r.ctrl[CB_BLINK +: 2] == BLINK_OFF)
        else $error("wrong mode after reset");

    a_reset_power_off : assert property (@(posedge mclk) disable iff (rst)
        $past(rst) |-> !osc_running && !bias_gen_en && vadj_en && !lcd_supply_detect_en)
        else $error("power controls wrong after reset");

    a_idle_no_scan : assert property (@(posedge mclk) disable iff (rst)
        !run |=> common_outputs == {NUM_COM{LVL_VDD}} && st_r.com_idx == 2'h0)
        else $error("scan active while display stopped");

    a_bypass_write : assert property (@(posedge mclk) disable iff (rst)
        (st_r.bus == BUS_ACK && avs_write && avs_address == REG_CTRL && avs_byteenable[0])
        |=> bypass_mid_res == $past(avs_writedata[CB_HALF]))
        else $error("bias bypass did not follow write");

    a_ptr_wrap : assert property (@(posedge mclk) disable iff (rst)
        (data_wr && st_r.ptr == RAM_LAST) |=> st_r.ptr == 5'h00)
        else $error("pointer did not wrap");

    a_slot_order : assert property (@(posedge mclk) disable iff (rst)
        (run && $past(run) && $changed(st_r.com_idx))
        |-> st_r.com_idx == $past(st_r.com_idx) + 2'h1)
        else $error("commons scanned out of order");

    a_bus_answer : assert property (@(posedge mclk) disable iff (rst)
        (st_r.bus == BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1
        avs_waitrequest) else $error("bus answer not one cycle");

endmodule : lcd_mux_drive

// file: sim/host_model.sv
// Host side model: an Avalon-MM master with write and read tasks.
// Assumes tb_top holds n_errors and summarize for a hung transfer.
`timescale 1ns/1ps
module host_model
    import lcd_drive_pkg::*;
(
    input wire logic mclk,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [3:0] avs_byteenable,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // Idle bus from time zero
    initial
    begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_byteenable = 4'h0;
        avs_writedata = 32'h0;
    end

    // Hold the request until waitrequest is sampled low, bounded
    task automatic wait_answer();
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (n >= 100)
        begin
            $display("Error: bus answer timed out");
            tb_top.n_errors++;
            tb_top.summarize();
        end
    endtask : wait_answer

    // One write; request raised one edge after the last release
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= 1'b1;
        wait_answer();
        avs_write <= 1'b0;
    endtask : wr

    // One read; data taken at the edge that sees waitrequest low
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_byteenable <= 4'hF;
        avs_read <= 1'b1;
        wait_answer();
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : rd
endmodule : host_model

// file: sim/tb_top.sv
// Testbench for the multiplexed LCD drive control.
// Assumes a 25 MHz clock and the host model as the only bus master.
`timescale 1ns/1ps
module tb_top;
    import lcd_drive_pkg::*;
    logic mclk;
    logic rst;
    logic [3:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2*NUM_COM-1:0] common_outputs;
    logic [2*NUM_SEG-1:0] segment_outputs;
    logic osc_running;
    logic bias_gen_en;
    logic bypass_mid_res;
    logic vadj_en;
    logic lcd_supply_detect_en;
    logic [3:0] voltage_step_field;
    logic [31:0] d;
    int n_errors = 0;
    int checks = 0;
    int n;

    lcd_mux_drive DUT (.mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .common_outputs(common_outputs),
        .segment_outputs(segment_outputs), .osc_running(osc_running),
        .bias_gen_en(bias_gen_en), .bypass_mid_res(bypass_mid_res), .vadj_en(vadj_en),
        .lcd_supply_detect_en(lcd_supply_detect_en), .voltage_step_field(voltage_step_field));

    host_model host (.mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // 40 ns clock
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        checks++;
        if (seen !== exp)
        begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask : check

    // Side outputs packed in one word
    function automatic logic [8:0] side();
        return {osc_running, bias_gen_en, bypass_mid_res, vadj_en, lcd_supply_detect_en,
            voltage_step_field};
    endfunction : side

    // Counts and verdict
    task automatic summarize();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // Main sequence
    initial
    begin
        rst = 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        check("com idle", common_outputs, 8'hFF);
        check("seg idle", segment_outputs, {88{1'b1}});
        check("side reset", side(), 9'h020);
        repeat (25000) @(posedge mclk);
        host.rd(REG_CTRL, d);
        check("ctrl reset", d, 32'h0000_0080);
        $display("test reset done");

        // Control fields reach their outputs; a write with no lanes is ignored
        host.wr(REG_CTRL, 32'h0000_150A, 4'hF);
        @(posedge mclk);
        check("side half", side(), 9'h0DA);
        host.wr(REG_CTRL, 32'h0000_0084, 4'hF);
        host.wr(REG_CTRL, 32'h0000_1FFF, 4'h0);
        host.rd(REG_CTRL, d);
        check("ctrl be0", d, 32'h0000_0084);
        check("no bypass", bypass_mid_res, 1'b0);
        host.rd(4'h2, d);
        check("unmapped", d, 32'h0);
        repeat (800) @(posedge mclk);
        check("no osc com", common_outputs, 8'hFF);
        $display("test control done");

        // Last address then wrap to byte zero
        host.wr(REG_PTR, {27'h0, RAM_LAST}, 4'hF);
        host.wr(REG_DATA, 32'h0000_00A5, 4'hF);
        host.wr(REG_DATA, 32'h0000_0021, 4'hF);
        host.wr(REG_PTR, {27'h0, RAM_LAST}, 4'hF);
        host.rd(REG_DATA, d);
        check("ram last", d, 32'h0000_00A5);
        host.wr(REG_PTR, 32'h0, 4'hF);
        host.rd(REG_DATA, d);
        check("ram wrap", d, 32'h0000_0021);
        $display("test memory done");

        // Scan at 160 Hz, slowest blink; bytes 0 and 21 light segments on commons 0 and 1
        host.wr(REG_CTRL, 32'h0000_00F5, 4'hF);
        n = 0;
        repeat (4) @(posedge mclk);
        check("com0 sel", common_outputs, 8'h57);
        check("seg com0", segment_outputs, {2'b10, 2'b00, {41{2'b10}}, 2'b00});
        while (common_outputs === 8'h57 && n < 50000)
        begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
        check("slot len", (n + 4 > SLOT_HI * TICK_CYC - TICK_CYC) &&
            (n + 4 < SLOT_HI * TICK_CYC + TICK_CYC), 1'b1);
        check("com1 sel", common_outputs, 8'h5D);
        check("seg com1", segment_outputs, {2'b00, {41{2'b10}}, 2'b00, 2'b10});
        host.rd(REG_STAT, d);
        check("stat com1", d, 32'h0000_0007);
        $display("test scan done");

        // Display off returns to idle
        host.wr(REG_CTRL, 32'h0000_0081, 4'hF);
        repeat (3) @(posedge mclk);
        check("off com", common_outputs, 8'hFF);
        check("off seg", segment_outputs, {88{1'b1}});
        $display("test off done");
        summarize();
    end
endmodule : tb_top
